// ### design/spl_map.svh
`ifndef SPL_MAP_SVH
`define SPL_MAP_SVH
// Serial command framing
`define SPL_OP_READ_PROT  8'h3C
`define SPL_HDR_LAST      6'h1F
`define SPL_OP_HI         31
`define SPL_OP_LO         24
`define SPL_SEC_LO        16
// Status byte one layout
`define SPL_SR_LOCK       7
`define SPL_SR_WPP        4
`define SPL_SR_SWP_HI     3
`define SPL_SR_SWP_LO     2
`define SPL_GLB_HI        5
`define SPL_GLB_LO        2
`define SPL_GLB_CLEAR     4'h0
`define SPL_GLB_SET       4'hF
// Protection summary codes
`define SPL_SWP_NONE      2'h0
`define SPL_SWP_SOME      2'h1
`define SPL_SWP_ALL       2'h3
// Reset values
`define SPL_LOCK_RST      1'h0
`define SPL_PROT_RST      1'h1
`endif

// ### design/spl_pkg.sv
package spl_pkg;
  // Commands arriving from the device's own command decoder
  typedef enum logic [1:0] {
    SPL_CMD_PROTECT   = 2'h0,
    SPL_CMD_UNPROTECT = 2'h1,
    SPL_CMD_WRSTAT    = 2'h2
  } spl_cmd_e_t;

  // One command strobe with its operands
  typedef struct packed {
    logic       valid;
    spl_cmd_e_t kind;
    logic [7:0] sector;
    logic [7:0] data;
  } spl_cmd_t;

  // Serial link phases, Gray along opcode -> data
  typedef enum logic [1:0] {
    SPL_ST_HDR  = 2'h0,
    SPL_ST_DATA = 2'h1,
    SPL_ST_SKIP = 2'h3
  } spl_state_t;
endpackage

// ### design/spl_top.sv
`timescale 1ns/1ps
`include "spl_map.svh"
// Overview of operation
// - Opcode 3Ch after select requests protection read
// - Three address bytes select containing sector
// - Output one bit per clock after address
// - Repeat all ones if protected, else zeros
// - First output byte may be stale
// - Deselect ends read, data line released
// - Read reports stored bit, never pin
// - Sector protection from its bit alone
// - Hardware lock needs pin low, lock set
// - Hardware lock ignores protect, unprotect, status write
// - Clearing lock performs no global operation
// - Lock resets to zero, pin low keeps it
// - Pin high still allows setting lock
// - Setting lock may do global protect too
// - Lock clear: all protection changes allowed
// - Soft lock may clear lock bit
// - Summary field: all, some, none protected
// - Only lock bit stored, rest live status
// - Global 0000 clears, 1111 sets, else none
module spl_top
  import spl_pkg::*;
#(
  parameter int SECTORS = 32,
  parameter int SEC_W   = $clog2(SECTORS)
) (
  // System clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  // Serial link from the host
  // Data in is taken on rising edges, data out moves on falling edges
  input  wire logic                 spi_sck,
  input  wire logic                 spi_cs_n,
  input  wire logic                 spi_mosi,
  output logic                      spi_miso_o,
  output logic                      spi_miso_oe,
  // Write-protect pin, active low
  input  wire logic                 wp_n,
  // Command strobe from the device decoder
  // Valid is a one-cycle strobe; back-to-back strobes are allowed
  input  wire spl_pkg::spl_cmd_t    cmd_in,
  // Protection state seen by the device
  // Bit n set means sector n is protected
  output logic [SECTORS-1:0]        sector_prot,
  output logic                      hw_locked,
  output logic [7:0]                status_byte
);
  import spl_pkg::*;

  // Summary of protection across the array
  // Only the none, some and all codes are ever produced
  function automatic logic [1:0] swp_of(input logic [SECTORS-1:0] v);
    logic [1:0] r;
    r = `SPL_SWP_SOME;
    if (&v) begin
      r = `SPL_SWP_ALL;
    end else if (~|v) begin
      r = `SPL_SWP_NONE;
    end
    return r;
  endfunction

  // ---------------- Link domain (serial clock) ----------------

  // Frame reset: deselect or system reset clears all link state
  // Chip select high holds every link register in reset, so a frame cut
  // mid-byte leaves nothing behind for the next one; the price is that no
  // link state survives between frames, which this read never needs
  wire logic                 frame_rst_n;
  assign frame_rst_n = rstn & ~spi_cs_n;

  spl_state_t                state_reg;      // Link phase
  spl_state_t                state_next;
  logic [5:0]                cnt_reg;        // Header bit count
  logic [5:0]                cnt_next;
  logic [31:0]               shift_reg;      // Opcode and address
  logic [31:0]               shift_next;
  logic [SEC_W-1:0]          sec_reg;        // Captured sector index
  logic [SEC_W-1:0]          sec_next;
  logic                      pbit_s1_reg;    // Sync stage one
  logic                      pbit_s2_reg;    // Sync stage two
  logic                      miso_reg;       // Driven data bit
  logic                      miso_oe_reg;    // Drive enable
  // Written on the system clock; only the first sync stage reads it
  logic                      rd_bit_reg;     // Bit handed to the link

  // Header decode as named wires
  wire logic                 hdr_done;
  wire logic                 op_match;
  assign shift_next = {shift_reg[30:0], spi_mosi};
  assign hdr_done   = (state_reg == SPL_ST_HDR) && (cnt_reg == `SPL_HDR_LAST);
  // Opcode sits in the top byte once the header is complete
  assign op_match   = (shift_next[`SPL_OP_HI:`SPL_OP_LO] == `SPL_OP_READ_PROT);
  // Any address in the sector picks it; low bits ignored
  assign sec_next   = hdr_done ? shift_next[`SPL_SEC_LO +: SEC_W] : sec_reg;
  // Counter holds at the last header bit for one edge, then runs on unused; deselect restarts it
  assign cnt_next   = hdr_done ? cnt_reg : cnt_reg + 6'h1;

  // Phase sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SPL_ST_HDR: begin
        // Other opcodes belong to other blocks; stay quiet
        if (hdr_done) begin
          state_next = op_match ? SPL_ST_DATA : SPL_ST_SKIP;
        end
      end
      SPL_ST_DATA: begin
        // Holds until deselect resets the frame
        state_next = SPL_ST_DATA;
      end
      SPL_ST_SKIP: begin
        // Foreign opcode: wait quietly for deselect
        state_next = SPL_ST_SKIP;
      end
      default: begin
        state_next = SPL_ST_SKIP;
      end
    endcase
  end

  // Header capture on rising edges
  // Shift keeps running in the data phase; nothing reads it then
  always_ff @(posedge spi_sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      state_reg <= SPL_ST_HDR;
      cnt_reg   <= 6'h0;
      shift_reg <= 32'h0000_0000;
      sec_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      sec_reg   <= sec_next;
    end
  end

  // Bring the looked-up bit onto the serial clock
  // Only two edges of latency; the stale first byte is tolerated
  // Reset to zero; the first bits may still carry sector 0's bit, looked up while the last frame's flag drained
  always_ff @(posedge spi_sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      pbit_s1_reg <= 1'h0;
      pbit_s2_reg <= 1'h0;
    end else begin
      pbit_s1_reg <= rd_bit_reg;
      pbit_s2_reg <= pbit_s1_reg;
    end
  end

  // Launch data on falling edges, released outside the data phase
  always_ff @(negedge spi_sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      miso_reg    <= 1'h0;
      miso_oe_reg <= 1'h0;
    end else begin
      // After the first byte every bit equals the stored bit: byte is all ones or zeros
      miso_reg    <= pbit_s2_reg;
      // Released through opcode and address phases
      miso_oe_reg <= (state_reg == SPL_ST_DATA);
    end
  end

  // Data and enable both leave straight from falling-edge flops
  assign spi_miso_o  = miso_reg;
  assign spi_miso_oe = miso_oe_reg;

  // ---------------- System domain ----------------

  logic                      rdy_s1_reg;     // Data-phase sync one
  logic                      rdy_s2_reg;     // Data-phase sync two
  logic                      wp_s1_reg;      // Pin sync one
  logic                      wp_s2_reg;      // Pin sync two
  logic                      lock_reg;       // Protection registers locked
  logic                      lock_next;
  logic [SECTORS-1:0]        prot_reg;       // Per-sector protection
  logic [SECTORS-1:0]        prot_next;
  logic                      hwl_reg;        // Hardware lock output
  logic [7:0]                sr_reg;         // Status byte readback

  // Crossings between the two clocks:
  // - data-phase flag: taken from the drive-enable flop, one bit that
  //   rises once per frame, so a plain two-stage synchroniser fits
  // - sector index: several bits, but frozen before the flag rises and
  //   only read while the synchronised flag is high, so no gray code
  // - looked-up bit: one bit, two stages on the serial clock
  // Level crossing of the data-phase flag and the pin
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdy_s1_reg <= 1'h0;
      rdy_s2_reg <= 1'h0;
      wp_s1_reg  <= 1'h1;
      wp_s2_reg  <= 1'h1;
    end else begin
      // Enable flop, not a state compare: header to skip flips two bits
      // and a decode of them could glitch high just as it is sampled
      rdy_s1_reg <= miso_oe_reg;
      rdy_s2_reg <= rdy_s1_reg;
      wp_s1_reg  <= wp_n;
      wp_s2_reg  <= wp_s1_reg;
    end
  end

  // Sector index is stable once the flag arrives, so it is safe to read
  // After deselect the index clears while the flag drains; the stray bit
  // is harmless, the next frame overwrites it before its second byte
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_bit_reg <= 1'h0;
    end else if (rdy_s2_reg) begin
      // Stored bit only; the pin never reaches this path
      rd_bit_reg <= prot_reg[sec_reg];
    end
  end

  // Lock and command decode
  // Lock states: open (lock 0, either pin), soft (lock 1, pin high) and
  // hard (lock 1, pin low); only open lets sector commands through and
  // only hard refuses status writes; power-up lands in open
  wire logic                 hw_lock;
  wire logic                 cmd_sec;
  wire logic                 cmd_ws;
  wire logic [3:0]           glb;
  wire logic                 glb_clear;
  wire logic                 glb_set;
  wire logic [SEC_W-1:0]     csec;
  wire logic                 new_lock;
  // Hardware locking needs the pin low and the lock bit set together
  assign hw_lock   = ~wp_s2_reg & lock_reg;
  assign cmd_sec   = cmd_in.valid && (cmd_in.kind != SPL_CMD_WRSTAT);
  assign cmd_ws    = cmd_in.valid && (cmd_in.kind == SPL_CMD_WRSTAT);
  assign glb       = cmd_in.data[`SPL_GLB_HI:`SPL_GLB_LO];
  assign glb_clear = (glb == `SPL_GLB_CLEAR);
  assign glb_set   = (glb == `SPL_GLB_SET);
  assign csec      = cmd_in.sector[SEC_W-1:0];
  assign new_lock  = cmd_in.data[`SPL_SR_LOCK];

  // Next protection and lock state
  always_comb begin
    prot_next = prot_reg;
    lock_next = lock_reg;
    if (cmd_sec) begin
      // Either lock state freezes single-sector changes
      if (!lock_reg) begin
        prot_next[csec] = (cmd_in.kind == SPL_CMD_PROTECT);
      end else begin
        // Soft or hard lock: command dropped, state kept
        prot_next = prot_reg;
      end
    end else if (cmd_ws) begin
      if (hw_lock) begin
        // Ignored outright; bits and lock keep their values
        prot_next = prot_reg;
      end else if (lock_reg) begin
        // Soft lock: lock bit may drop, protection stays untouched
        lock_next = new_lock;
      end else begin
        // Unlocked: lock may rise with a global operation
        lock_next = new_lock;
        if (glb_clear) begin
          prot_next = '0;
        end else if (glb_set) begin
          prot_next = '1;
        end
      end
    end
  end

  // Protection state; power-up clears the lock, protects all sectors
  // All sectors start protected so nothing is writable before software opens it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lock_reg <= `SPL_LOCK_RST;
      prot_reg <= {SECTORS{`SPL_PROT_RST}};
    end else begin
      lock_reg <= lock_next;
      prot_reg <= prot_next;
    end
  end

  // Status readback: stored lock plus live pin and summary
  // Pin bit is the synchronised level and lags the pin by three cycles
  // Bits outside lock, pin and summary read as zero
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sr_reg  <= 8'h00;
      hwl_reg <= 1'h0;
    end else begin
      sr_reg                               <= 8'h00;
      sr_reg[`SPL_SR_LOCK]                 <= lock_reg;
      sr_reg[`SPL_SR_WPP]                  <= wp_s2_reg;
      sr_reg[`SPL_SR_SWP_HI:`SPL_SR_SWP_LO] <= swp_of(prot_reg);
      hwl_reg                              <= hw_lock;
    end
  end

  // Array protection follows the bit only, never the pin
  assign sector_prot = prot_reg;
  assign hw_locked   = hwl_reg;
  assign status_byte = sr_reg;

endmodule

// ### tb/spl_host.sv
`timescale 1ns/1ps
// Host on the serial link, mode 0; its clock stands still between frames
module spl_host (
  // Link pins
  output logic      sck,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic oe,
  // What the last frame saw
  output logic      oe_hdr,
  output logic      oe_any
);
  initial begin
    sck = 0;
    cs_n = 1;
    mosi = 0;
  end
  // Opcode then address MSB first, then nb bits out; q keeps the last byte
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input int nb, output logic [7:0] q);
    logic [31:0] w;
    w = {op, a};
    q = 8'h00;
    oe_hdr = 0;
    oe_any = 0;
    #1.3 cs_n = 0;
    for (int i = 0; i < 32 + nb; i++) begin
      // Data phase input is don't-care, so keep it moving
      mosi = (i < 32) ? w[31-i] : ~mosi;
      #62.5 sck = 1;
      if (i < 32 && oe) oe_hdr = 1;
      if (oe) oe_any = 1;
      // A released line shows the inverse, so a missing drive cannot pass
      q = {q[6:0], oe ? miso : ~miso};
      #62.5 sck = 0;
    end
    // Deselect may fall mid-byte
    #20 cs_n = 1;
    mosi = ~mosi;
  endtask
endmodule

// ### tb/spl_top_asserts.sv
`timescale 1ns/1ps
// Watches protection state, lock gating and the data-out enable
module spl_chk
  import spl_pkg::*;
#(parameter int SECTORS = 32) (
  // System side
  input wire logic               sys_clk,
  input wire logic               rstn,
  input wire logic               wp_n,
  input wire spl_pkg::spl_cmd_t  cmd_in,
  input wire logic [SECTORS-1:0] sector_prot,
  input wire logic               hw_locked,
  input wire logic [7:0]         status_byte,
  // Link side
  input wire logic               spi_cs_n,
  input wire logic               spi_miso_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // status_byte[7] is the lock only when no command landed the cycle before
  a_soft_lock_hold: assert property (cmd_in.valid && cmd_in.kind != SPL_CMD_WRSTAT && status_byte[7]
    && !$past(cmd_in.valid) |=> $stable(sector_prot)) else $error("locked sector command changed protection");
  a_open_protect: assert property (cmd_in.valid && cmd_in.kind == SPL_CMD_PROTECT && !status_byte[7]
    && !$past(cmd_in.valid) |=> sector_prot[$past(cmd_in.sector[4:0])]) else $error("protect not applied");
  a_glob_clear: assert property (cmd_in.valid && cmd_in.kind == SPL_CMD_WRSTAT && cmd_in.data[5:2] == 4'h0
    && !status_byte[7] && !$past(cmd_in.valid) |=> sector_prot == '0) else $error("global clear missed");
  a_glob_set: assert property (cmd_in.valid && cmd_in.kind == SPL_CMD_WRSTAT && cmd_in.data[5:2] == 4'hF
    && !status_byte[7] && !$past(cmd_in.valid) |=> &sector_prot) else $error("global set missed");
  a_unlock_noglob: assert property (cmd_in.valid && cmd_in.kind == SPL_CMD_WRSTAT && !cmd_in.data[7]
    && status_byte[7] && !$past(cmd_in.valid) |=> $stable(sector_prot)) else $error("global during unlock");
  a_hw_lock_def: assert property (hw_locked == (status_byte[7] && !status_byte[4])) else $error("hw lock mismatch");
  a_hw_lock_hold: assert property (hw_locked && !wp_n && !$past(wp_n) && !$past(wp_n, 2) && cmd_in.valid
    |=> $stable(sector_prot)) else $error("hw locked state changed");
  a_summary: assert property ($past(rstn) |-> status_byte[3:2] == (&$past(sector_prot) ? 2'h3 :
    (|$past(sector_prot) ? 2'h1 : 2'h0))) else $error("summary field wrong");
  a_cs_release: assert property (spi_cs_n |-> !spi_miso_oe) else $error("data out driven while idle");
endmodule
bind spl_top spl_chk #(.SECTORS(SECTORS)) u_chk (.sys_clk(sys_clk), .rstn(rstn), .wp_n(wp_n), .cmd_in(cmd_in),
  .sector_prot(sector_prot), .hw_locked(hw_locked), .status_byte(status_byte), .spi_cs_n(spi_cs_n),
  .spi_miso_oe(spi_miso_oe));

// ### tb/spl_top_tb_top.sv
`timescale 1ns/1ps
module spl_top_tb_top;
  import spl_pkg::*;
  // One command with the state it should leave
  typedef struct packed {
    spl_cmd_e_t  kind;
    logic [7:0]  sec;
    logic [7:0]  dat;
    logic [31:0] prot;
    logic [7:0]  sb;
  } spl_row_t;
  logic        sys_clk = 0;
  logic        rstn = 0;
  logic        wp_n = 1;
  spl_cmd_t    cmd_in = '0;
  wire logic   sck, cs_n, mosi, miso, oe, oe_hdr, oe_any;
  logic [31:0] sector_prot;
  logic        hw_locked;
  logic [7:0]  status_byte, q;
  int          errors = 0;
  int          num_checks = 0;
  // Pin high throughout; starts from power-up state
  spl_row_t rows [9] = '{
    '{SPL_CMD_WRSTAT, 8'h00, 8'h00, 32'h0000_0000, 8'h10},
    '{SPL_CMD_PROTECT, 8'h05, 8'h00, 32'h0000_0020, 8'h14},
    '{SPL_CMD_WRSTAT, 8'h00, 8'h3C, 32'hFFFF_FFFF, 8'h1C},
    '{SPL_CMD_UNPROTECT, 8'h1F, 8'h00, 32'h7FFF_FFFF, 8'h14},
    '{SPL_CMD_WRSTAT, 8'h00, 8'h24, 32'h7FFF_FFFF, 8'h14},
    '{SPL_CMD_WRSTAT, 8'h00, 8'h80, 32'h0000_0000, 8'h90},
    '{SPL_CMD_PROTECT, 8'h03, 8'h00, 32'h0000_0000, 8'h90},
    '{SPL_CMD_WRSTAT, 8'h00, 8'h3C, 32'h0000_0000, 8'h10},
    '{SPL_CMD_WRSTAT, 8'h00, 8'hBC, 32'hFFFF_FFFF, 8'h9C}};
  always #2.5 sys_clk = ~sys_clk;
  spl_host host (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso), .oe(oe), .oe_hdr(oe_hdr), .oe_any(oe_any));
  spl_top DUT (.sys_clk(sys_clk), .rstn(rstn), .spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .spi_miso_o(miso), .spi_miso_oe(oe), .wp_n(wp_n), .cmd_in(cmd_in), .sector_prot(sector_prot),
    .hw_locked(hw_locked), .status_byte(status_byte));
  task results;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // One strobe, then room for status to settle
  task cmd(input spl_cmd_e_t k, input logic [7:0] s, input logic [7:0] d);
    @(posedge sys_clk);
    cmd_in <= '{1'b1, k, s, d};
    @(posedge sys_clk);
    cmd_in.valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  task rd(input logic [23:0] a, input logic [7:0] e);
    host.rd(8'h3C, a, 24, q);
    chk("read byte", 32'(e), 32'(q));
    chk("oe in header", 32'h0000_0000, 32'(oe_hdr));
    chk("oe in data", 32'h0000_0001, 32'(oe_any));
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1;
    repeat (3) @(posedge sys_clk);
    chk("prot reset", 32'hFFFF_FFFF, sector_prot);
    chk("status reset", 32'h0000_001C, 32'(status_byte));
    foreach (rows[i]) begin
      cmd(rows[i].kind, rows[i].sec, rows[i].dat);
      chk("row prot", rows[i].prot, sector_prot);
      chk("row status", 32'(rows[i].sb), 32'(status_byte));
    end
    wp_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("hw lock", 32'h0000_0001, 32'(hw_locked));
    cmd(SPL_CMD_WRSTAT, 8'h00, 8'h00);
    cmd(SPL_CMD_UNPROTECT, 8'h09, 8'h00);
    chk("hw prot", 32'hFFFF_FFFF, sector_prot);
    chk("hw status", 32'h0000_008C, 32'(status_byte));
    wp_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    cmd(SPL_CMD_WRSTAT, 8'h00, 8'h00);
    cmd(SPL_CMD_UNPROTECT, 8'h09, 8'h00);
    chk("unlock prot", 32'hFFFF_FDFF, sector_prot);
    // Pin low must not leak into the read
    wp_n <= 1'b0;
    rd(24'h09_5A3C, 8'h00);
    rd(24'h0A_FFFF, 8'hFF);
    host.rd(8'h3C, 24'h0A_0000, 13, q);
    @(posedge sys_clk);
    chk("oe after cut", 32'h0000_0000, 32'(oe));
    host.rd(8'h03, 24'h09_0000, 16, q);
    chk("oe bad opcode", 32'h0000_0000, 32'(oe_any));
    // Lock with the pin low; while the pin stays low only a power cycle may release it
    cmd(SPL_CMD_WRSTAT, 8'h00, 8'hF0);
    chk("hard lock status", 32'h0000_0084, 32'(status_byte));
    chk("hard lock flag", 32'h0000_0001, 32'(hw_locked));
    cmd(SPL_CMD_WRSTAT, 8'h00, 8'h0F);
    chk("hard unlock refused", 32'h0000_0084, 32'(status_byte));
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk("power cycle status", 32'h0000_000C, 32'(status_byte));
    chk("power cycle prot", 32'hFFFF_FFFF, sector_prot);
    results;
  end
  // Reads take about 26 us; far beyond that is a hang
  initial begin
    #200000;
    errors++;
    results;
  end
endmodule
